// >>> inc/osd_pkg.sv
// Package for the octal serial driver control block.
// Assumes a 32-bit AXI4-Lite register bus and eight output channels.
package osd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int          OSD_CHANNELS    = 8;
  localparam int          OSD_ADDR_W      = 8;
  localparam int          OSD_DATA_W      = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0]  OSD_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OSD_OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OSD_OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0]  OSD_OFF_IRQ_MSK = 8'h0C;
  localparam logic [7:0]  OSD_OFF_SHIFT   = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int          OSD_CTRL_OFF_B  = 0;
  localparam logic        OSD_CTRL_RST    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int          OSD_ST_DATA_LSB = 0;
  localparam int          OSD_ST_OC_LSB   = 8;
  localparam int          OSD_ST_OT_B     = 16;
  localparam int          OSD_ST_EN_B     = 17;
  localparam int          OSD_ST_FLT_B    = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask fields
  localparam int          OSD_IRQ_W       = 4;
  localparam int          OSD_IRQ_STROBE  = 0;
  localparam int          OSD_IRQ_OC      = 1;
  localparam int          OSD_IRQ_OT      = 2;
  localparam int          OSD_IRQ_WORD    = 3;
  localparam logic [3:0]  OSD_IRQ_ST_RST  = 4'h0;
  localparam logic [3:0]  OSD_IRQ_MSK_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of the driver state
  localparam logic [7:0]  OSD_DATA_RST    = 8'h00;
  localparam logic [7:0]  OSD_OC_RST      = 8'h00;
  localparam logic [7:0]  OSD_SHIFT_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Serial word length and AXI responses
  localparam logic [3:0]  OSD_WORD_BITS   = 4'h8;
  localparam logic [1:0]  OSD_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  OSD_RESP_SLVERR = 2'h2;

endpackage

// >>> verilog/osd_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; the first stage feeds the
// second stage only.
module osd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage, read by the second stage only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
    end
    else
    begin
      meta_reg <= i_async;
    end
  end

  // Second stage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

// >>> verilog/osd_top.sv
// Control logic of an octal low-side serial driver with AXI4-Lite status.
// Assumes i_clk at 10 MHz and all pin inputs asynchronous to it; the
// serial clock is sampled and its edges found in the i_clk domain.
//
// Contract
// - Shifted bits leave on the serial output so devices can be chained.
// - A strobe latches eight shifted bits; bit n set turns channel n on.
// - Over-current on one channel shuts only that channel off.
// - Over-current shutdown is held per channel after the cause goes away.
// - The next latched word frees a shut channel; its new bit decides.
// - Fault flag is low while any channel is held off by over-current.
// - The next data strobe while enabled clears the fault latch and the low flag.
// - Over-temperature forces all eight channels off.
// - Thermal shutdown lasts exactly while the over-temperature input holds.
// - Enable gates both the output drivers and the storage register.
module osd_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Driver pins
  input  wire logic        i_enable,
  input  wire logic        i_serial_in,
  input  wire logic        i_serial_clk,
  input  wire logic        i_latch_strobe,
  input  wire logic [7:0]  i_overcurrent_ind,
  input  wire logic        i_overtemp_ind,
  output logic             o_serial_out,
  output logic [7:0]       o_drive_out,
  output logic             o_drive_en,
  output logic             o_fault_flag_n,
  output logic             o_irq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  oc_sync;
  logic [4:0]  pin_sync;
  logic        en_s;
  logic        si_s;
  logic        sck_s;
  logic        str_s;
  logic        ot_s;
  logic        sck_d_reg;
  logic        str_d_reg;
  logic        ot_d_reg;
  logic        sck_rise;
  logic        strobe;
  logic        take_word;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  data_reg;
  logic [7:0]  oc_reg;
  logic [7:0]  oc_next;
  logic [7:0]  oc_set;
  logic [7:0]  drive_next;
  logic        soft_off_reg;
  logic [3:0]  irq_st_reg;
  logic [3:0]  irq_msk_reg;
  logic [3:0]  irq_ev;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_val;
  logic        rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write paths
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    addr_hit = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic addr_known(input logic [7:0] addr);
    addr_known = addr_hit(addr, osd_pkg::OSD_OFF_CTRL)
               | addr_hit(addr, osd_pkg::OSD_OFF_STATUS)
               | addr_hit(addr, osd_pkg::OSD_OFF_IRQ_ST)
               | addr_hit(addr, osd_pkg::OSD_OFF_IRQ_MSK)
               | addr_hit(addr, osd_pkg::OSD_OFF_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  osd_sync #(
    .WIDTH (5)
  ) u_sync_ctl (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_overtemp_ind, i_latch_strobe, i_serial_clk,
               i_serial_in, i_enable}),
    .o_sync  (pin_sync)
  );

  osd_sync #(
    .WIDTH (8)
  ) u_sync_oc (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_overcurrent_ind),
    .o_sync  (oc_sync)
  );

  assign en_s  = pin_sync[0];
  assign si_s  = pin_sync[1];
  assign sck_s = pin_sync[2];
  assign str_s = pin_sync[3];
  assign ot_s  = pin_sync[4];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sck_d_reg <= 1'b0;
      str_d_reg <= 1'b0;
      ot_d_reg  <= 1'b0;
    end
    else
    begin
      sck_d_reg <= sck_s;
      str_d_reg <= str_s;
      ot_d_reg  <= ot_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_d_reg;
  assign strobe    = str_s & ~str_d_reg;
  assign take_word = strobe & en_s;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain and serial output
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      shift_reg <= osd_pkg::OSD_SHIFT_RST;
    end
    else if (sck_rise)
    begin
      shift_reg <= {shift_reg[6:0], si_s};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_serial_out <= 1'b0;
    end
    else
    begin
      o_serial_out <= shift_reg[7];
    end
  end

  // Counts bits since the last strobe, saturating at a full word
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bit_cnt_reg <= 4'h0;
    end
    else if (strobe)
    begin
      bit_cnt_reg <= 4'h0;
    end
    else if (sck_rise && bit_cnt_reg != osd_pkg::OSD_WORD_BITS)
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage latch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      data_reg <= osd_pkg::OSD_DATA_RST;
    end
    else if (take_word)
    begin
      data_reg <= shift_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel over-current latch; a new fault wins over the strobe clear
  assign oc_set  = oc_sync & o_drive_out;
  assign oc_next = (oc_reg & ~{8{take_word}}) | oc_set;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      oc_reg <= osd_pkg::OSD_OC_RST;
    end
    else
    begin
      oc_reg <= oc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers
  always_comb
  begin
    drive_next = data_reg & ~oc_next;
    if (ot_s || !en_s || soft_off_reg)
    begin
      drive_next = 8'h00;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_drive_out <= 8'h00;
      o_drive_en  <= 1'b0;
    end
    else
    begin
      o_drive_out <= drive_next;
      o_drive_en  <= en_s;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_fault_flag_n <= 1'b1;
    end
    else
    begin
      o_fault_flag_n <= ~|oc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set wins
  assign irq_ev[osd_pkg::OSD_IRQ_STROBE] = take_word;
  assign irq_ev[osd_pkg::OSD_IRQ_OC]     = |(oc_set & ~oc_reg);
  assign irq_ev[osd_pkg::OSD_IRQ_OT]     = ot_s & ~ot_d_reg;
  assign irq_ev[osd_pkg::OSD_IRQ_WORD]   = sck_rise
    && (bit_cnt_reg == osd_pkg::OSD_WORD_BITS - 4'h1);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_st_reg <= osd_pkg::OSD_IRQ_ST_RST;
    end
    else if (wr_fire && wstrb_reg[0]
             && addr_hit(awaddr_reg, osd_pkg::OSD_OFF_IRQ_ST))
    begin
      irq_st_reg <= (irq_st_reg & ~wdata_reg[3:0]) | irq_ev;
    end
    else
    begin
      irq_st_reg <= irq_st_reg | irq_ev;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      soft_off_reg <= osd_pkg::OSD_CTRL_RST;
      irq_msk_reg  <= osd_pkg::OSD_IRQ_MSK_RST;
    end
    else if (wr_fire && wstrb_reg[0])
    begin
      if (addr_hit(awaddr_reg, osd_pkg::OSD_OFF_CTRL))
      begin
        soft_off_reg <= wdata_reg[osd_pkg::OSD_CTRL_OFF_B];
      end
      if (addr_hit(awaddr_reg, osd_pkg::OSD_OFF_IRQ_MSK))
      begin
        irq_msk_reg <= wdata_reg[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= osd_pkg::OSD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_reg    <= s_axi_awaddr;
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(awaddr_reg) ? osd_pkg::OSD_RESP_OKAY
                                               : osd_pkg::OSD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    if (addr_hit(s_axi_araddr, osd_pkg::OSD_OFF_CTRL))
    begin
      rd_val[osd_pkg::OSD_CTRL_OFF_B] = soft_off_reg;
    end
    else if (addr_hit(s_axi_araddr, osd_pkg::OSD_OFF_STATUS))
    begin
      rd_val[osd_pkg::OSD_ST_DATA_LSB +: 8] = data_reg;
      rd_val[osd_pkg::OSD_ST_OC_LSB +: 8]   = oc_reg;
      rd_val[osd_pkg::OSD_ST_OT_B]          = ot_s;
      rd_val[osd_pkg::OSD_ST_EN_B]          = en_s;
      rd_val[osd_pkg::OSD_ST_FLT_B]         = o_fault_flag_n;
    end
    else if (addr_hit(s_axi_araddr, osd_pkg::OSD_OFF_IRQ_ST))
    begin
      rd_val[3:0] = irq_st_reg;
    end
    else if (addr_hit(s_axi_araddr, osd_pkg::OSD_OFF_IRQ_MSK))
    begin
      rd_val[3:0] = irq_msk_reg;
    end
    else if (addr_hit(s_axi_araddr, osd_pkg::OSD_OFF_SHIFT))
    begin
      rd_val[7:0] = shift_reg;
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= osd_pkg::OSD_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? osd_pkg::OSD_RESP_OKAY
                             : osd_pkg::OSD_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> verif/osd_top_assertions.sv
// Checker for the pin behaviour of osd_top.
// Assumes it is bound to osd_top and sees only its ports.
module osd_top_chk (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_enable,
  input wire logic       i_serial_clk,
  input wire logic       i_latch_strobe,
  input wire logic [7:0] i_overcurrent_ind,
  input wire logic       i_overtemp_ind,
  input wire logic       o_serial_out,
  input wire logic [7:0] o_drive_out,
  input wire logic       o_drive_en,
  input wire logic       o_fault_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  reset_off_a: assert property (disable iff (1'h0)
    i_rst |=> o_drive_out == 8'h00 && o_fault_flag_n && !o_drive_en)
    else $error("outputs not cleared by reset");
  drive_gate_a: assert property (
    !o_drive_en |-> o_drive_out == 8'h00)
    else $error("outputs on while disabled");
  enable_follow_a: assert property (
    $stable(i_enable) [*5] |-> o_drive_en == i_enable)
    else $error("driver enable does not follow pin");
  ot_off_a: assert property (
    i_overtemp_ind [*5] |-> o_drive_out == 8'h00)
    else $error("outputs on during over-temperature");
  ot_release_a: assert property (
    o_drive_out != 8'h00 |->
      !($past(i_overtemp_ind, 3) && $past(i_overtemp_ind, 4)))
    else $error("outputs released while over-temperature");
  fault_drop_a: assert property (
    $fell(o_fault_flag_n) |-> ($past(o_drive_out) & ~o_drive_out) != 8'h00)
    else $error("fault flag low without shut channel");
  oc_only_a: assert property (
    $fell(o_fault_flag_n) |-> ($past(o_drive_out) & ~o_drive_out
      & ~($past(i_overcurrent_ind, 2) | $past(i_overcurrent_ind, 3)
      | $past(i_overcurrent_ind, 4))) == 8'h00)
    else $error("healthy channel shut down");
  flag_clear_a: assert property (
    $rose(o_fault_flag_n) |-> $past(i_latch_strobe, 3)
      || $past(i_latch_strobe, 4) || $past(i_latch_strobe, 5))
    else $error("fault flag cleared without strobe");
  shift_edge_a: assert property (
    $changed(o_serial_out) |-> $past(i_serial_clk, 3)
      || $past(i_serial_clk, 4) || $past(i_serial_clk, 5))
    else $error("serial output moved without clock");

  cover property (!o_fault_flag_n);
  cover property (o_drive_out == 8'hFF);
  cover property (i_overtemp_ind && o_drive_en);
endmodule

bind osd_top osd_top_chk u_osd_top_chk (.*);

// >>> verif/osd_ctl_model.sv
// Behavioural controller driving the serial chain of osd_top.
// Assumes i_clk is the 100 ns bench clock; serial clock period 800 ns.
module osd_ctl_model (
  input  wire logic i_clk,
  output logic      o_serial_clk,
  output logic      o_serial_in,
  output logic      o_latch_strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_serial_clk = 1'h0;
    o_serial_in = 1'h0;
    o_latch_strobe = 1'h0;
  end

  // Clock stands low between bits; data goes inverse after hold
  task automatic send_bit(input logic b);
    @(posedge i_clk) o_serial_in <= b;
    repeat (2) @(posedge i_clk);
    o_serial_clk <= 1'h1;
    repeat (4) @(posedge i_clk);
    o_serial_clk <= 1'h0;
    repeat (1) @(posedge i_clk);
    o_serial_in <= ~b;
  endtask

  // First bit sent ends at channel 8
  task automatic send_word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--)
      send_bit(w[i]);
  endtask

  task automatic strobe();
    @(posedge i_clk) o_latch_strobe <= 1'h1;
    repeat (4) @(posedge i_clk);
    o_latch_strobe <= 1'h0;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// >>> verif/osd_top_tb.sv
// Self-checking bench for osd_top.
// Assumes osd_ctl_model drives the serial pins and AXI4-Lite reaches regs.
module osd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'h0, i_rst = 1'h1, i_enable = 1'h1;
  logic        i_serial_in, i_serial_clk, i_latch_strobe;
  logic [7:0]  i_overcurrent_ind = 8'h00;
  logic        i_overtemp_ind = 1'h0;
  logic        o_serial_out, o_drive_en, o_fault_flag_n, o_irq;
  logic [7:0]  o_drive_out;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_fail = 0, total_checks = 0;

  osd_top u_osd_top (.*);
  osd_ctl_model u_ctl (
    .i_clk          (i_clk),
    .o_serial_clk   (i_serial_clk),
    .o_serial_in    (i_serial_in),
    .o_latch_strobe (i_latch_strobe)
  );

  initial
  begin
    forever #50 i_clk = ~i_clk;
  end

  ////////////////////////////////////////
  task stop_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tmo(input int n);
    if (n > 50)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge i_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
      tmo(n);
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge i_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
      tmo(n);
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(r, osd_pkg::OSD_RESP_OKAY);
    check(d, e);
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, osd_pkg::OSD_RESP_OKAY);
  endtask

  task settle();
    repeat (8) @(posedge i_clk);
  endtask

  ////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  c;
    c = 8'h3C;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    settle();
    check(o_drive_out, 8'h00);
    check(o_fault_flag_n, 1'h1);
    rd_chk(osd_pkg::OSD_OFF_STATUS, 32'h0006_0000);
    axi_rd(8'h20, d, r);
    check(r, osd_pkg::OSD_RESP_SLVERR);
    axi_wr(8'h24, 32'h1, r);
    check(r, osd_pkg::OSD_RESP_SLVERR);
    // A shifted word leaves on the serial output, first bit first
    u_ctl.send_word(c);
    for (int i = 7; i >= 0; i--)
    begin
      check(o_serial_out, c[i]);
      u_ctl.send_bit(1'h0);
    end
    u_ctl.send_word(8'hA5);
    u_ctl.strobe();
    check(o_drive_out, 8'hA5);
    // Disabled: no drive and storage refuses the word
    @(posedge i_clk) i_enable <= 1'h0;
    u_ctl.send_word(8'hFF);
    u_ctl.strobe();
    check(o_drive_out, 8'h00);
    check(o_drive_en, 1'h0);
    @(posedge i_clk) i_enable <= 1'h1;
    settle();
    check(o_drive_out, 8'hA5);
    u_ctl.strobe();
    check(o_drive_out, 8'hFF);
    // Over-current on channel 3 only
    @(posedge i_clk) i_overcurrent_ind <= 8'h04;
    settle();
    check(o_drive_out, 8'hFB);
    check(o_fault_flag_n, 1'h0);
    @(posedge i_clk) i_overcurrent_ind <= 8'h00;
    settle();
    check(o_drive_out, 8'hFB);
    rd_chk(osd_pkg::OSD_OFF_STATUS, 32'h0002_04FF);
    // Interrupt masked, raised, cleared
    check(o_irq, 1'h0);
    wr_ok(osd_pkg::OSD_OFF_IRQ_MSK, 32'h2);
    settle();
    check(o_irq, 1'h1);
    rd_chk(osd_pkg::OSD_OFF_IRQ_MSK, 32'h2);
    wr_ok(osd_pkg::OSD_OFF_IRQ_ST, 32'h2);
    settle();
    check(o_irq, 1'h0);
    rd_chk(osd_pkg::OSD_OFF_IRQ_ST, 32'h9);
    u_ctl.send_word(8'h24);
    u_ctl.strobe();
    check(o_drive_out, 8'h24);
    check(o_fault_flag_n, 1'h1);
    // Over-temperature holds every channel off
    @(posedge i_clk) i_overtemp_ind <= 1'h1;
    settle();
    check(o_drive_out, 8'h00);
    u_ctl.send_word(8'h81);
    u_ctl.strobe();
    check(o_drive_out, 8'h00);
    @(posedge i_clk) i_overtemp_ind <= 1'h0;
    settle();
    check(o_drive_out, 8'h81);
    rd_chk(osd_pkg::OSD_OFF_SHIFT, 32'h81);
    rd_chk(osd_pkg::OSD_OFF_IRQ_ST, 32'hD);
    // Software off holds every channel low until released
    wr_ok(osd_pkg::OSD_OFF_CTRL, 32'h1);
    settle();
    check(o_drive_out, 8'h00);
    rd_chk(osd_pkg::OSD_OFF_CTRL, 32'h1);
    wr_ok(osd_pkg::OSD_OFF_CTRL, 32'h0);
    settle();
    check(o_drive_out, 8'h81);
    stop_test();
  end
endmodule
